/* core/irq_flag_enable_wakeup.sv */
// peripheral interrupt flags, enables and pin wake-up with wishbone slave
`timescale 1ns/100ps
module irq_flag_enable_wakeup (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // wishbone classic slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [9:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // asynchronous pins
   input  wire logic        i_low_battery_compare_out,
   input  wire logic        i_ext2_pin,
   input  wire logic [7:0]  i_port1,
   input  wire logic [7:0]  i_port2,
   input  wire logic [7:0]  i_port3,
   // same-clock event pulses
   input  wire logic        i_touch_done,
   input  wire logic        i_adc_done,
   input  wire logic        i_pwm5_period_full,
   input  wire logic        i_rtc_interval_reached,
   // same-clock request levels of sources flagged elsewhere
   input  wire logic        i_ext0_req,
   input  wire logic        i_timer0_req,
   input  wire logic        i_ext1_req,
   input  wire logic        i_timer1_req,
   input  wire logic        i_serial_req,
   input  wire logic        i_timer2_req,
   input  wire logic        i_spi_req,
   input  wire logic        i_i2c_master_req,
   // vector entry, one-hot pulse per vector-cleared source
   input  wire logic [4:0]  i_vector_clear,
   // to the core
   output logic      [13:0] o_irq_req,
   output logic             o_wake_stop,
   output logic             o_wake_halt
);

   // registers
   logic [7:0]  peripheral_irq_flags;
   logic [7:0]  port1_wake_enable;
   logic [7:0]  port3_port2_wake_enable;
   logic [7:0]  irq_enable_primary;
   logic [7:0]  irq_enable_secondary;

   // synchronisers and edge history
   logic        lb_meta;
   logic        lb_sync;
   logic        lb_prev;
   logic        ext2_meta;
   logic        ext2_sync;
   logic        ext2_prev;
   logic [15:0] pin_meta;
   logic [15:0] pin_sync;
   logic [15:0] pin_prev;
   logic [1:0]  settle;
   logic        settled;

   logic [15:0] pin_raw;
   logic [15:0] pin_wake_mask;
   logic [7:0]  flag_set;
   logic [7:0]  flag_keep;
   logic [7:0]  wr_index;
   logic        wr_strobe;
   logic        rd_strobe;
   logic [7:0]  next_rd_data;
   logic [13:0] next_irq_req;
   logic        next_wake_stop;
   logic        next_wake_halt;

   // map a vector-clear bit onto the matching flag position
   function automatic logic [7:0] vector_to_flags(input logic [4:0] vc);
      logic [7:0] m;
      m = 8'h00;
      m[irq_flag_pkg::FLG_LOW_BATTERY] = vc[irq_flag_pkg::VC_LOWBAT];
      m[irq_flag_pkg::FLG_PWM]         = vc[irq_flag_pkg::VC_PWM];
      m[irq_flag_pkg::FLG_EXT2]        = vc[irq_flag_pkg::VC_EXT2];
      m[irq_flag_pkg::FLG_PIN_CHANGE]  = vc[irq_flag_pkg::VC_PIN_CHANGE];
      m[irq_flag_pkg::FLG_RTC]         = vc[irq_flag_pkg::VC_RTC];
      return m;
   endfunction : vector_to_flags

   // register select for one index, shared by every writable register
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [7:0] idx,
                                    input logic [7:0] target);
      return strobe && (idx == target);
   endfunction : reg_hit

   // pins in wake-enable order: second register above port 1
   // port 2 bits outside 5:4 are never watched
   assign pin_raw = {i_port3[7:4], i_port2[5:4], i_port3[1:0], i_port1};
   assign pin_wake_mask = {port3_port2_wake_enable, port1_wake_enable};

   // low-battery comparator synchroniser; only the second stage is read
   // the comparator is slow and both of its edges matter
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lb_meta <= 1'b0;
         lb_sync <= 1'b0;
      end else begin
         lb_meta <= i_low_battery_compare_out;
         lb_sync <= lb_meta;
      end
   end

   // ext2 pin synchroniser, reset to the idle-high pin level
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ext2_meta <= 1'b1;
         ext2_sync <= 1'b1;
      end else begin
         ext2_meta <= i_ext2_pin;
         ext2_sync <= ext2_meta;
      end
   end

   // port pin synchronisers, one chain per bit
   // pins moving together may still be seen a cycle apart
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta <= 16'h0000;
         pin_sync <= 16'h0000;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // edge history, one cycle behind the synchronised levels
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lb_prev   <= 1'b0;
         ext2_prev <= 1'b1;
         pin_prev  <= 16'h0000;
      end else begin
         lb_prev   <= lb_sync;
         ext2_prev <= ext2_sync;
         pin_prev  <= pin_sync;
      end
   end

   // settle counter; stops when full, so it never wraps and
   // reopens the blind window in mid-run
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         settle <= 2'h0;
      end else if (!settled) begin
         settle <= settle + 2'h1;
      end
   end

   // reset levels are guesses, so no edge is believed before settling
   // costs three cycles of blindness after reset
   assign settled = (settle == irq_flag_pkg::SETTLE_CYCLES);

   // hardware set terms
   always_comb begin
      flag_set = 8'h00;
      flag_set[irq_flag_pkg::FLG_LOW_BATTERY] = settled & (lb_sync ^ lb_prev);
      flag_set[irq_flag_pkg::FLG_TOUCH]       = i_touch_done;
      flag_set[irq_flag_pkg::FLG_ADC]         = i_adc_done;
      flag_set[irq_flag_pkg::FLG_PWM]         = i_pwm5_period_full;
      // falling edge, independent of the ext2 enable
      flag_set[irq_flag_pkg::FLG_EXT2]        = settled & ext2_prev & ~ext2_sync;
      // any enabled pin that changed; pin-change enable plays no part
      flag_set[irq_flag_pkg::FLG_PIN_CHANGE]  =
         settled & (|((pin_sync ^ pin_prev) & pin_wake_mask));
      flag_set[irq_flag_pkg::FLG_RTC]         = i_rtc_interval_reached;
   end

   // bus decode: byte lane 0 carries the eight register bits
   // no wait states: every request is answered on the next edge
   // writes with lane 0 off are acked but store nothing
   assign wr_index  = i_wb_adr[9:2];
   assign wr_strobe = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & ~o_wb_ack;
   assign rd_strobe = i_wb_cyc & i_wb_stb & ~o_wb_ack;

   // flags surviving this cycle's clears
   always_comb begin
      flag_keep = ~vector_to_flags(i_vector_clear);
      if (reg_hit(wr_strobe, wr_index, irq_flag_pkg::IDX_FLAGS)) begin
         // zero bits clear, one bits leave the flag alone
         flag_keep = flag_keep & i_wb_dat[7:0];
      end
   end

   // flag register; a set in the clearing cycle wins
   // an event on the edge of a software or vector clear is kept,
   // at the cost of a second entry for that source
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         peripheral_irq_flags <= irq_flag_pkg::RST_FLAGS;
      end else begin
         peripheral_irq_flags <= ((peripheral_irq_flags & flag_keep) | flag_set)
                                 & irq_flag_pkg::FLAGS_IMPL;
      end
   end

   // port 1 wake enables, one bit per pin
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         port1_wake_enable <= irq_flag_pkg::RST_WAKE;
      end else if (reg_hit(wr_strobe, wr_index, irq_flag_pkg::IDX_P1_WAKE)) begin
         port1_wake_enable <= i_wb_dat[7:0];
      end
   end

   // port 3 / port 2 wake enables; bit order follows the pin map,
   // not the port numbering, so it is no port image
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         port3_port2_wake_enable <= irq_flag_pkg::RST_WAKE;
      end else if (reg_hit(wr_strobe, wr_index, irq_flag_pkg::IDX_P3P2_WAKE)) begin
         port3_port2_wake_enable <= i_wb_dat[7:0];
      end
   end

   // primary enables; bit 6 is unimplemented and stores zero
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_enable_primary <= irq_flag_pkg::RST_EN;
      end else if (reg_hit(wr_strobe, wr_index, irq_flag_pkg::IDX_EN_PRI)) begin
         irq_enable_primary <= i_wb_dat[7:0] & irq_flag_pkg::EN_PRI_IMPL;
      end
   end

   // secondary enables, all eight bits implemented
   // a write reaches the requests one cycle later
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_enable_secondary <= irq_flag_pkg::RST_EN;
      end else if (reg_hit(wr_strobe, wr_index, irq_flag_pkg::IDX_EN_SEC)) begin
         irq_enable_secondary <= i_wb_dat[7:0];
      end
   end

   // read mux; unmapped indices answer zero
   always_comb begin
      unique case (wr_index)
         irq_flag_pkg::IDX_FLAGS:     next_rd_data = peripheral_irq_flags;
         irq_flag_pkg::IDX_P1_WAKE:   next_rd_data = port1_wake_enable;
         irq_flag_pkg::IDX_P3P2_WAKE: next_rd_data = port3_port2_wake_enable;
         irq_flag_pkg::IDX_EN_PRI:    next_rd_data = irq_enable_primary;
         irq_flag_pkg::IDX_EN_SEC:    next_rd_data = irq_enable_secondary;
         default:                     next_rd_data = 8'h00;
      endcase
   end

   // one-cycle ack, dropped the cycle after; every address is answered
   // so a stray access never hangs the bus
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= rd_strobe;
      end
   end

   // read data, held until the next request
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_dat <= 32'h0000_0000;
      end else if (rd_strobe) begin
         o_wb_dat <= {24'h00_0000, next_rd_data};
      end
   end

   // request gating, global enable over per-source enable
   // sources flagged elsewhere pass as levels; their owners clear them
   // registered, so a request trails its flag by one cycle
   always_comb begin
      next_irq_req = 14'h0000;
      next_irq_req[irq_flag_pkg::REQ_EXT0]   =
         i_ext0_req & irq_enable_primary[irq_flag_pkg::EN_EXT0];
      next_irq_req[irq_flag_pkg::REQ_TIMER0] =
         i_timer0_req & irq_enable_primary[irq_flag_pkg::EN_TIMER0];
      next_irq_req[irq_flag_pkg::REQ_EXT1]   =
         i_ext1_req & irq_enable_primary[irq_flag_pkg::EN_EXT1];
      next_irq_req[irq_flag_pkg::REQ_TIMER1] =
         i_timer1_req & irq_enable_primary[irq_flag_pkg::EN_TIMER1];
      next_irq_req[irq_flag_pkg::REQ_SERIAL] =
         i_serial_req & irq_enable_primary[irq_flag_pkg::EN_SERIAL];
      next_irq_req[irq_flag_pkg::REQ_TIMER2] =
         i_timer2_req & irq_enable_primary[irq_flag_pkg::EN_TIMER2];
      next_irq_req[irq_flag_pkg::REQ_RTC]    =
         peripheral_irq_flags[irq_flag_pkg::FLG_RTC]
         & irq_enable_secondary[irq_flag_pkg::EN_RTC];
      next_irq_req[irq_flag_pkg::REQ_PIN_CHANGE] =
         peripheral_irq_flags[irq_flag_pkg::FLG_PIN_CHANGE]
         & irq_enable_secondary[irq_flag_pkg::EN_PIN_CHG];
      next_irq_req[irq_flag_pkg::REQ_EXT2]   =
         peripheral_irq_flags[irq_flag_pkg::FLG_EXT2]
         & irq_enable_secondary[irq_flag_pkg::EN_EXT2];
      // one shared request for both converters
      next_irq_req[irq_flag_pkg::REQ_ADC_TOUCH] =
         (peripheral_irq_flags[irq_flag_pkg::FLG_ADC]
          | peripheral_irq_flags[irq_flag_pkg::FLG_TOUCH])
         & irq_enable_secondary[irq_flag_pkg::EN_ADC_TOUCH];
      next_irq_req[irq_flag_pkg::REQ_SPI]    =
         i_spi_req & irq_enable_secondary[irq_flag_pkg::EN_SPI];
      next_irq_req[irq_flag_pkg::REQ_LOWBAT] =
         peripheral_irq_flags[irq_flag_pkg::FLG_LOW_BATTERY]
         & irq_enable_secondary[irq_flag_pkg::EN_LOWBAT];
      next_irq_req[irq_flag_pkg::REQ_PWM]    =
         peripheral_irq_flags[irq_flag_pkg::FLG_PWM]
         & irq_enable_secondary[irq_flag_pkg::EN_PWM];
      next_irq_req[irq_flag_pkg::REQ_I2C]    =
         i_i2c_master_req & irq_enable_secondary[irq_flag_pkg::EN_I2C];
      if (!irq_enable_primary[irq_flag_pkg::EN_GLOBAL]) begin
         next_irq_req = 14'h0000;
      end
   end

   // wake terms ignore the global enable so a sleeping core can be woken
   // pin-change wake has no enable beyond the per-pin ones
   always_comb begin
      next_wake_stop =
         (i_ext0_req & irq_enable_primary[irq_flag_pkg::EN_EXT0])
         | (i_ext1_req & irq_enable_primary[irq_flag_pkg::EN_EXT1])
         | (peripheral_irq_flags[irq_flag_pkg::FLG_EXT2]
            & irq_enable_secondary[irq_flag_pkg::EN_EXT2])
         | peripheral_irq_flags[irq_flag_pkg::FLG_PIN_CHANGE];
      next_wake_halt = next_wake_stop
         | (peripheral_irq_flags[irq_flag_pkg::FLG_PWM]
            & irq_enable_secondary[irq_flag_pkg::EN_PWM])
         | (peripheral_irq_flags[irq_flag_pkg::FLG_RTC]
            & irq_enable_secondary[irq_flag_pkg::EN_RTC]);
   end

   // registered requests; a request falls the cycle after its flag clears
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_req <= 14'h0000;
      end else begin
         o_irq_req <= next_irq_req;
      end
   end

   // registered wake levels, glitch-free towards a sleeping core
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wake_stop <= 1'b0;
         o_wake_halt <= 1'b0;
      end else begin
         o_wake_stop <= next_wake_stop;
         o_wake_halt <= next_wake_halt;
      end
   end

endmodule : irq_flag_enable_wakeup

/* common/irq_flag_pkg.sv */
// constants for the peripheral interrupt flag, enable and wake-up block
package irq_flag_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FLAGS     = 8'h95;
   localparam logic [7:0] IDX_P1_WAKE   = 8'h96;
   localparam logic [7:0] IDX_P3P2_WAKE = 8'hA1;
   localparam logic [7:0] IDX_EN_PRI    = 8'hA8;
   localparam logic [7:0] IDX_EN_SEC    = 8'hA9;

   // reset values
   localparam logic [7:0] RST_FLAGS     = 8'h00;
   localparam logic [7:0] RST_WAKE      = 8'h00;
   localparam logic [7:0] RST_EN        = 8'h00;

   // flag register bit positions, bit 6 is reserved and reads zero
   localparam int FLG_LOW_BATTERY = 7;
   localparam int FLG_TOUCH       = 5;
   localparam int FLG_ADC         = 4;
   localparam int FLG_PWM         = 3;
   localparam int FLG_EXT2        = 2;
   localparam int FLG_PIN_CHANGE  = 1;
   localparam int FLG_RTC         = 0;
   localparam logic [7:0] FLAGS_IMPL = 8'hBF;

   // software clear patterns, one flag written as zero
   localparam logic [7:0] CLR_LOW_BATTERY = 8'h7F;
   localparam logic [7:0] CLR_TOUCH       = 8'hDF;
   localparam logic [7:0] CLR_ADC         = 8'hEF;
   localparam logic [7:0] CLR_PWM         = 8'hF7;
   localparam logic [7:0] CLR_EXT2        = 8'hFB;
   localparam logic [7:0] CLR_PIN_CHANGE  = 8'hFD;
   localparam logic [7:0] CLR_RTC         = 8'hFE;

   // primary enable bits
   localparam int EN_GLOBAL = 7;
   localparam int EN_TIMER2 = 5;
   localparam int EN_SERIAL = 4;
   localparam int EN_TIMER1 = 3;
   localparam int EN_EXT1   = 2;
   localparam int EN_TIMER0 = 1;
   localparam int EN_EXT0   = 0;
   localparam logic [7:0] EN_PRI_IMPL = 8'hBF;

   // secondary enable bits
   localparam int EN_I2C       = 7;
   localparam int EN_PWM       = 6;
   localparam int EN_LOWBAT    = 5;
   localparam int EN_SPI       = 4;
   localparam int EN_ADC_TOUCH = 3;
   localparam int EN_EXT2      = 2;
   localparam int EN_PIN_CHG   = 1;
   localparam int EN_RTC       = 0;

   // request output positions
   localparam int REQ_EXT0       = 0;
   localparam int REQ_TIMER0     = 1;
   localparam int REQ_EXT1       = 2;
   localparam int REQ_TIMER1     = 3;
   localparam int REQ_SERIAL     = 4;
   localparam int REQ_TIMER2     = 5;
   localparam int REQ_RTC        = 6;
   localparam int REQ_PIN_CHANGE = 7;
   localparam int REQ_EXT2       = 8;
   localparam int REQ_ADC_TOUCH  = 9;
   localparam int REQ_SPI        = 10;
   localparam int REQ_LOWBAT     = 11;
   localparam int REQ_PWM        = 12;
   localparam int REQ_I2C        = 13;
   localparam int NUM_REQ        = 14;

   // vector clear positions
   localparam int VC_LOWBAT     = 0;
   localparam int VC_PWM        = 1;
   localparam int VC_EXT2       = 2;
   localparam int VC_PIN_CHANGE = 3;
   localparam int VC_RTC        = 4;
   localparam int NUM_VC        = 5;

   // cycles before pin edge detection is trusted after reset
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;
endpackage : irq_flag_pkg

/* sim/irq_flag_monitor.sv */
// checker for bus, request and wake relations of the interrupt block
`timescale 1ns/100ps
module irq_flag_monitor (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [9:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_adc_done,
   input wire logic        i_timer0_req,
   input wire logic        i_ext0_req,
   input wire logic        i_ext1_req,
   input wire logic        i_rtc_interval_reached,
   input wire logic [4:0]  i_vector_clear,
   input wire logic [13:0] o_irq_req,
   input wire logic        o_wake_stop,
   input wire logic        o_wake_halt
);
   logic [7:0] pri;
   logic [7:0] sec;
   logic       take;
   logic       ext_wake_on;
   assign ext_wake_on = (i_ext0_req && pri[0]) || (i_ext1_req && pri[2]);
   assign take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];
   // shadow enables, updated on the same edge the slave stores them
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pri <= 8'h00;
         sec <= 8'h00;
      end else if (take && i_wb_adr[9:2] == irq_flag_pkg::IDX_EN_PRI) begin
         pri <= i_wb_dat[7:0];
      end else if (take && i_wb_adr[9:2] == irq_flag_pkg::IDX_EN_SEC) begin
         sec <= i_wb_dat[7:0];
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_ack_follows: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
      else $error("request not acked next cycle");
   a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   a_flag_read: assert property ((o_wb_ack && $past(i_wb_adr[9:2]) == 8'h95)
      |-> (o_wb_dat[6] == 1'b0 && o_wb_dat[31:8] == 24'h000000))
      else $error("flag read shows reserved bits");
   a_global_block: assert property ((!pri[7] && $past(!pri[7])) |-> o_irq_req == 14'h0000)
      else $error("request with global enable off");
   a_timer0_gate: assert property (o_irq_req[1] == $past(i_timer0_req && pri[1] && pri[7]))
      else $error("timer0 request gating wrong");
   a_adc_request: assert property (i_adc_done ##1 (sec[3] && pri[7]) |=> o_irq_req[9])
      else $error("adc event gave no request");
   a_vector_drop: assert property ((i_vector_clear[4] && !i_rtc_interval_reached) |=> ##1 !o_irq_req[6])
      else $error("rtc request stays after vector");
   a_ext_wake: assert property (ext_wake_on |=> (o_wake_stop && o_wake_halt))
      else $error("enabled ext0 or ext1 request gave no wake");
endmodule : irq_flag_monitor
bind irq_flag_enable_wakeup irq_flag_monitor mon_u (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
   .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_adc_done,
   .i_timer0_req, .i_ext0_req, .i_ext1_req, .i_rtc_interval_reached, .i_vector_clear,
   .o_irq_req, .o_wake_stop, .o_wake_halt);

/* sim/core_vector_model.sv */
// core model: takes vectored requests and names the source it enters
`timescale 1ns/100ps
module core_vector_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_enable,
   input  wire logic [7:0]  i_delay,
   input  wire logic [13:0] i_irq_req,
   output logic      [4:0]  o_vector_clear
);
   logic [4:0] pend;
   int         cnt;
   // only vector-cleared sources, in clear-bit order
   assign pend = {i_irq_req[6], i_irq_req[7], i_irq_req[8], i_irq_req[12], i_irq_req[11]};
   // wait i_delay cycles, pulse one source; hold off so a still-standing
   // request is not entered twice
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         o_vector_clear <= 5'h00;
      end else begin
         o_vector_clear <= 5'h00;
         if (!i_enable || pend == 5'h00) begin
            cnt <= (cnt < 0) ? cnt + 1 : 0;
         end else if (cnt >= int'(i_delay)) begin
            o_vector_clear <= pend & (~pend + 5'h01);
            cnt <= -3;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : core_vector_model

/* sim/tb.sv */
// self-checking bench for the interrupt flag, enable and wake-up block
`timescale 1ns/100ps
module tb;
   localparam logic [7:0] FL = 8'h95;
   localparam logic [7:0] EP = 8'hA8;
   localparam logic [7:0] ES = 8'hA9;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        ack;
   logic        lbat = 1'b0;
   logic        ext2 = 1'b1;
   logic [7:0]  p1 = 8'h00;
   logic [7:0]  p2 = 8'h00;
   logic [7:0]  p3 = 8'h00;
   logic [3:0]  ev = 4'h0;
   logic [7:0]  src = 8'h00;
   logic [4:0]  vclr;
   logic [13:0] irq;
   logic        wstop;
   logic        whalt;
   logic        core_en = 1'b0;
   logic [7:0]  core_dly = 8'h02;
   logic [31:0] q;
   int          error_cnt = 0;
   int          tests_run = 0;
   always #20 clk = ~clk;
   irq_flag_enable_wakeup dut_u (
      .i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_low_battery_compare_out(lbat), .i_ext2_pin(ext2), .i_port1(p1), .i_port2(p2),
      .i_port3(p3), .i_touch_done(ev[0]), .i_adc_done(ev[1]), .i_pwm5_period_full(ev[2]),
      .i_rtc_interval_reached(ev[3]), .i_ext0_req(src[0]), .i_timer0_req(src[1]),
      .i_ext1_req(src[2]), .i_timer1_req(src[3]), .i_serial_req(src[4]),
      .i_timer2_req(src[5]), .i_spi_req(src[6]), .i_i2c_master_req(src[7]),
      .i_vector_clear(vclr), .o_irq_req(irq), .o_wake_stop(wstop), .o_wake_halt(whalt));
   core_vector_model core_u (.i_clk(clk), .i_rst(rst), .i_enable(core_en),
      .i_delay(core_dly), .i_irq_req(irq), .o_vector_clear(vclr));
   task automatic test_done;
      if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one classic cycle; the request holds until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         error_cnt++;
         test_done();
      end
   endtask : wb
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 8'h00);
      chk("register", exp, q);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   // single-cycle event: 0 touch, 1 adc, 2 pwm, 3 rtc
   task automatic fire(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
   endtask : fire
   initial begin
      #2000000;
      error_cnt++;
      test_done();
   end
   initial begin
      logic [7:0] idxs [5] = '{FL, 8'h96, 8'hA1, EP, ES};
      int bits [4] = '{5, 4, 3, 0};
      int reqs [4] = '{9, 9, 12, 6};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      idle(8);
      foreach (idxs[i]) rd(idxs[i], 32'h0);
      rd(8'h97, 32'h0);
      wb(1'b1, 8'h96, 8'hFF);
      rd(8'h96, 32'hFF);
      wb(1'b1, 8'hA1, 8'hA5);
      rd(8'hA1, 32'hA5);
      wb(1'b1, EP, 8'hFF);
      rd(EP, 32'hBF);
      wb(1'b1, ES, 8'hFF);
      rd(ES, 32'hFF);
      for (int i = 0; i < 4; i++) begin
         fire(i);
         rd(FL, 32'h1 << bits[i]);
         chk("request on", 32'h1, 32'(irq[reqs[i]]));
         wb(1'b1, FL, ~(8'h01 << bits[i]));
         rd(FL, 32'h0);
         idle(2);
         chk("request off", 32'h0, 32'(irq[reqs[i]]));
      end
      fire(1);
      fire(3);
      wb(1'b1, FL, 8'hEF);
      rd(FL, 32'h01);
      wb(1'b1, EP, 8'h7F);
      idle(2);
      chk("global off", 32'h0, 32'(irq));
      chk("halt wake", 32'h1, {30'h0, wstop, whalt});
      wb(1'b1, EP, 8'hFF);
      idle(2);
      chk("global on", 32'h40, 32'(irq));
      wb(1'b1, FL, 8'hFE);
      src <= 8'hFF;
      idle(3);
      chk("sources", 32'h243F, 32'(irq));
      chk("wake", 32'h3, {30'h0, wstop, whalt});
      for (int b = 0; b < 6; b++) begin
         wb(1'b1, EP, 8'hFF & ~(8'h01 << b));
         idle(2);
         chk("source gate", 32'h243F & ~(32'h1 << b), 32'(irq));
      end
      wb(1'b1, EP, 8'hFA);
      wb(1'b1, ES, 8'h6F);
      idle(2);
      chk("wake off", 32'h0, 32'(wstop));
      chk("secondary gate", 32'h003A, 32'(irq));
      src <= 8'h00;
      wb(1'b1, EP, 8'hFF);
      wb(1'b1, ES, 8'hFB);
      ext2 <= 1'b0;
      idle(8);
      rd(FL, 32'h04);
      chk("ext2 wake off", 32'h0, 32'(wstop));
      wb(1'b1, ES, 8'hFF);
      idle(2);
      chk("ext2 wake", 32'h1, 32'(wstop));
      chk("ext2 request", 32'h1, 32'(irq[8]));
      wb(1'b1, FL, 8'hFB);
      ext2 <= 1'b1;
      lbat <= 1'b1;
      idle(8);
      rd(FL, 32'h80);
      wb(1'b1, FL, 8'h7F);
      lbat <= 1'b0;
      idle(8);
      rd(FL, 32'h80);
      wb(1'b1, FL, 8'h7F);
      wb(1'b1, 8'h96, 8'h01);
      p1 <= 8'h02;
      idle(8);
      rd(FL, 32'h00);
      p1 <= 8'h03;
      idle(8);
      rd(FL, 32'h02);
      chk("pin request", 32'h1, 32'(irq[7]));
      wb(1'b1, FL, 8'hFD);
      wb(1'b1, 8'hA1, 8'h08);
      p2 <= 8'h20;
      idle(8);
      rd(FL, 32'h02);
      wb(1'b1, FL, 8'hFD);
      core_en <= 1'b1;
      fire(3);
      idle(12);
      rd(FL, 32'h00);
      core_dly <= 8'h09;
      fire(2);
      idle(20);
      rd(FL, 32'h00);
      lbat <= 1'b1;
      idle(24);
      rd(FL, 32'h00);
      test_done();
   end
endmodule : tb
